// [cfg_msg_endpoint.sv]
`timescale 1ns/1ps
`include "cfg_msg_map.svh"

module cfg_msg_endpoint (
   input wire logic clk, // Core clock.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic rxValid, // Incoming token present.
   input wire cfg_msg_pkg::token_t rxTok, // Incoming token.
   output logic rxReady, // Endpoint accepts a token.
   output logic txValid, // Outgoing token present.
   output cfg_msg_pkg::token_t txTok, // Outgoing token.
   input wire logic txReady, // Interconnect takes the token.
   output logic [23:0] replyDest, // Return channel-end for reply.
   output logic busy // Request in progress.
);

   // ---------------------------------------------------------------
   // Declarations.
   // ---------------------------------------------------------------

   cfg_msg_pkg::state_t state; // Sequencer state.
   logic isRead; // Current request is a read.
   logic bad; // Malformed sequence seen.
   logic [2:0] cnt; // Byte counter within a field.
   logic [23:0] retId; // Collected return identifier.
   logic [15:0] regNum; // Collected register number.
   logic [31:0] wdata; // Collected write data.
   logic [31:0] rdata; // Stored word read back.
   logic [2:0] txIdx; // Reply token index.
   logic [2:0] txLen; // Reply length in tokens.
   logic ok; // Access succeeded.
   logic memWe; // Register store write strobe.
   logic rxFire; // Token accepted this cycle.
   logic txFire; // Token delivered this cycle.

   assign rxFire = rxValid && rxReady;
   assign txFire = txValid && txReady;

   // Shift a byte into the low end of a word, earlier bytes moving up.
   function automatic logic [31:0] shiftIn(input logic [31:0] w, input logic [7:0] b);
      shiftIn = {w[23:0], b};
   endfunction

   // Register number is valid when it falls in the implemented range.
   function automatic logic regValid(input logic [15:0] n);
      regValid = (n < 16'(`REG_COUNT));
   endfunction

   // ---------------------------------------------------------------
   // Register store.
   // ---------------------------------------------------------------

   assign memWe = (state == cfg_msg_pkg::S_EXEC) && !isRead && !bad && regValid(regNum);

   cfg_reg_mem u_mem (
      .clk(clk),
      .rst_b(rst_b),
      .we(memWe),
      .addr(regNum[`REG_AW-1:0]),
      .wdata(wdata),
      .rdata(rdata)
   );

   // ---------------------------------------------------------------
   // Request sequencer.
   // ---------------------------------------------------------------

   // Walk the request fields one token at a time.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= cfg_msg_pkg::S_IDLE;
         cnt <= 3'h0;
         isRead <= 1'b0;
         bad <= 1'b0;
      end else begin
         case (state)
            cfg_msg_pkg::S_IDLE: begin
               // A header token starts a request; anything else is dropped.
               if (rxFire && rxTok.ctrl) begin
                  isRead <= (rxTok.data == `TOK_READ);
                  bad <= !(rxTok.data == `TOK_READ || rxTok.data == `TOK_WRITE);
                  cnt <= 3'h0;
                  if (rxTok.data == `TOK_READ || rxTok.data == `TOK_WRITE) begin
                     state <= cfg_msg_pkg::S_RET;
                  end
               end
            end
            cfg_msg_pkg::S_RET: begin
               // Three bytes of return identifier.
               if (rxFire) begin
                  if (rxTok.ctrl) begin
                     bad <= 1'b1;
                  end
                  cnt <= (cnt == 3'h2) ? 3'h0 : cnt + 3'h1;
                  if (cnt == 3'h2) begin
                     state <= cfg_msg_pkg::S_REGN;
                  end
               end
            end
            cfg_msg_pkg::S_REGN: begin
               // Two bytes of register number, then data for a write.
               if (rxFire) begin
                  if (rxTok.ctrl) begin
                     bad <= 1'b1;
                  end
                  cnt <= (cnt == 3'h1) ? 3'h0 : cnt + 3'h1;
                  if (cnt == 3'h1) begin
                     state <= isRead ? cfg_msg_pkg::S_END : cfg_msg_pkg::S_DATA;
                  end
               end
            end
            cfg_msg_pkg::S_DATA: begin
               // Four data bytes for a write.
               if (rxFire) begin
                  if (rxTok.ctrl) begin
                     bad <= 1'b1;
                  end
                  cnt <= (cnt == 3'h3) ? 3'h0 : cnt + 3'h1;
                  if (cnt == 3'h3) begin
                     state <= cfg_msg_pkg::S_END;
                  end
               end
            end
            cfg_msg_pkg::S_END: begin
               // The closing token must be control token 1.
               if (rxFire) begin
                  if (!(rxTok.ctrl && rxTok.data == `TOK_END)) begin
                     bad <= 1'b1;
                  end
                  state <= cfg_msg_pkg::S_EXEC;
               end
            end
            cfg_msg_pkg::S_EXEC: begin
               // Perform the access; the read word is ready next cycle.
               state <= cfg_msg_pkg::S_REPLY;
            end
            cfg_msg_pkg::S_REPLY: begin
               // Suppressed writes finish at once.
               if (txLen == 3'h0 || (txFire && txIdx == txLen - 3'h1)) begin
                  state <= cfg_msg_pkg::S_IDLE;
               end
            end
            default: begin
               state <= cfg_msg_pkg::S_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Field capture.
   // ---------------------------------------------------------------

   // Assemble fields most significant byte first.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         retId <= 24'h000000;
         regNum <= 16'h0000;
         wdata <= 32'h0000_0000;
      end else if (rxFire) begin
         if (state == cfg_msg_pkg::S_RET) begin
            retId <= 24'(shiftIn({8'h00, retId}, rxTok.data));
         end
         if (state == cfg_msg_pkg::S_REGN) begin
            regNum <= 16'(shiftIn({16'h0000, regNum}, rxTok.data));
         end
         if (state == cfg_msg_pkg::S_DATA) begin
            wdata <= shiftIn(wdata, rxTok.data);
         end
      end
   end

   // ---------------------------------------------------------------
   // Reply outcome.
   // ---------------------------------------------------------------

   // Decide success and reply length at execution time.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ok <= 1'b0;
         txLen <= 3'h0;
         replyDest <= 24'h000000;
      end else if (state == cfg_msg_pkg::S_EXEC) begin
         ok <= !bad && regValid(regNum);
         replyDest <= retId;
         if (!isRead && !bad && retId[7:0] == `NO_REPLY_LOW) begin
            txLen <= 3'h0;
         end else if (isRead && !bad && regValid(regNum)) begin
            txLen <= 3'h6;
         end else begin
            txLen <= 3'h2;
         end
      end
   end

   // ---------------------------------------------------------------
   // Reply transmitter.
   // ---------------------------------------------------------------

   // Emit ack or nack, optional data bytes high first, then end token.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         txIdx <= 3'h0;
         txValid <= 1'b0;
         txTok <= '0;
      end else if (state == cfg_msg_pkg::S_REPLY && txLen != 3'h0) begin
         if (!txValid || txReady) begin
            if (txValid && txIdx == txLen - 3'h1) begin
               txValid <= 1'b0;
               txIdx <= 3'h0;
            end else begin
               txValid <= 1'b1;
               txIdx <= txValid ? txIdx + 3'h1 : 3'h0;
            end
         end
         if (!txValid) begin
            txTok <= '{ctrl: 1'b1, data: ok ? `TOK_ACK : `TOK_NACK};
         end else if (txReady) begin
            if (txIdx + 3'h1 == txLen - 3'h1) begin
               txTok <= '{ctrl: 1'b1, data: `TOK_END};
            end else begin
               txTok <= '{ctrl: 1'b0, data: rdata[8'(5'(31 - 8 * txIdx)) -: 8]};
            end
         end
      end else begin
         txValid <= 1'b0;
         txIdx <= 3'h0;
      end
   end

   // Handshake and status flags from flip-flops.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rxReady <= 1'b0;
         busy <= 1'b0;
      end else begin
         rxReady <= (state != cfg_msg_pkg::S_EXEC) && (state != cfg_msg_pkg::S_REPLY)
                    && !(rxFire && state == cfg_msg_pkg::S_END);
         busy <= (state != cfg_msg_pkg::S_IDLE);
      end
   end

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------

   sequence sq_exec_write;
      state == cfg_msg_pkg::S_EXEC && !isRead && !bad && retId[7:0] == `NO_REPLY_LOW;
   endsequence

   // A clean read of an implemented register is executing.
   sequence sq_read_ok;
      state == cfg_msg_pkg::S_EXEC && isRead && !bad && regValid(regNum);
   endsequence

   quiet_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      sq_exec_write |=> !txValid [*3]) else $error("Suppressed write produced a reply.");

   first_token_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(txValid) |-> txTok.ctrl && (txTok.data == `TOK_ACK || txTok.data == `TOK_NACK))
      else $error("Reply did not open with ack or nack.");

   bad_nack_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state == cfg_msg_pkg::S_EXEC && bad) |-> ##[1:4] (txValid && txTok.data == `TOK_NACK))
      else $error("Malformed request not answered with failure.");

   write_store_a: assert property (@(posedge clk) disable iff (!rst_b)
      memWe |-> $past(state == cfg_msg_pkg::S_END && rxFire && rxTok.ctrl
                      && rxTok.data == `TOK_END)) else $error("Store written without a clean end token.");

   // A good read opens its reply with the success token two cycles on.
   read_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
      sq_read_ok |-> ##2 (txValid && txTok.ctrl && txTok.data == `TOK_ACK))
      else $error("Good read did not open with ack.");

   // The last token delivered in every reply is the closing control token.
   reply_end_a: assert property (@(posedge clk) disable iff (!rst_b)
      (txFire && txIdx == txLen - 3'h1) |-> (txTok.ctrl && txTok.data == `TOK_END))
      else $error("Reply did not close with the end token.");

endmodule

// [cfg_msg_map.svh]
`ifndef CFG_MSG_MAP_SVH
`define CFG_MSG_MAP_SVH

// ---------------------------------------------------------------
// Message tokens.
// ---------------------------------------------------------------
`define TOK_WRITE 8'hC0
`define TOK_READ 8'hC1
`define TOK_END 8'h01
`define TOK_ACK 8'h03
`define TOK_NACK 8'h04
`define NO_REPLY_LOW 8'hFF

// ---------------------------------------------------------------
// Register file layout.
// ---------------------------------------------------------------
`define REG_COUNT 16
`define REG_AW 4
`define REG_RESET 32'h0000_0000

`endif

// [cfg_msg_pkg.sv]
package cfg_msg_pkg;

   // Byte of a message with its control-token marker.
   typedef struct packed {
      logic ctrl;
      logic [7:0] data;
   } token_t;

   // Receive sequencer states.
   typedef enum logic [3:0] {
      S_IDLE, S_RET, S_REGN, S_DATA, S_END, S_EXEC, S_REPLY, S_DRAIN
   } state_t;

endpackage

// [cfg_reg_mem.sv]
`timescale 1ns/1ps
`include "cfg_msg_map.svh"

// Small register store with registered read data.
module cfg_reg_mem (
   input wire logic clk, // Core clock.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic we, // Write strobe.
   input wire logic [`REG_AW-1:0] addr, // Word index.
   input wire logic [31:0] wdata, // Write data.
   output logic [31:0] rdata // Registered read data.
);

   // Storage words.
   logic [31:0] mem [`REG_COUNT];

   // -------------------------------------------------------------
   // Write and read ports.
   // -------------------------------------------------------------

   // Store on write and present the addressed word a cycle later.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < `REG_COUNT; i++) begin
            mem[i] <= `REG_RESET;
         end
         rdata <= `REG_RESET;
      end else begin
         if (we) begin
            mem[addr] <= wdata;
         end
         rdata <= mem[addr];
      end
   end

endmodule

// [cfg_requester_model.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Remote requesting channel-end.
// ----------------------------------------------------------------
module cfg_requester_model (
   input wire logic clk, // Core clock.
   input wire logic slow, // Stall the reply sink at random.
   output cfg_msg_pkg::token_t rxTok, // Request token to the endpoint.
   output logic rxValid, // Request token present.
   input wire logic rxReady, // Endpoint accepts the token.
   input wire logic txValid, // Reply token present.
   input wire cfg_msg_pkg::token_t txTok, // Reply token.
   output logic txReady // Reply sink ready.
);
   cfg_msg_pkg::token_t gotQ[$]; // Reply tokens taken so far.

   // Idle values hold until the first request.
   initial begin
      rxValid = 1'b0;
      rxTok = '0;
   end

   // Sink readiness changes on the falling edge, stalling when asked.
   always @(negedge clk) begin
      txReady <= slow ? (($urandom & 3) != 0) : 1'b1;
   end

   // Every reply token taken by the sink is queued for the bench.
   always @(posedge clk) begin
      if (txValid && txReady) begin
         gotQ.push_back(txTok);
      end
   end

   // Presents one token and holds it until the endpoint takes it.
   task automatic sendTok(input cfg_msg_pkg::token_t t);
      @(negedge clk);
      rxValid = 1'b1;
      rxTok = t;
      do @(posedge clk); while (rxReady !== 1'b1);
   endtask

   // Releases the request lines; the bus then shows the inverted last token.
   task automatic relTok();
      @(negedge clk);
      rxValid = 1'b0;
      rxTok = ~rxTok;
   endtask
endmodule

// [tb.sv]
`timescale 1ns/1ps
`include "cfg_msg_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("Error %0t: got %h expected %h", $time, g, e); end end

// ----------------------------------------------------------------
// Self-checking bench for the configuration endpoint.
// ----------------------------------------------------------------
module tb;
   logic clk; // Core clock.
   logic rst_b; // Reset, active low.
   logic slow; // Random reply stalls on.
   logic rxValid; // Request token present.
   cfg_msg_pkg::token_t rxTok; // Request token.
   logic rxReady; // Endpoint accepts.
   logic txValid; // Reply token present.
   cfg_msg_pkg::token_t txTok; // Reply token.
   logic txReady; // Sink ready.
   logic [23:0] replyDest; // Return channel-end.
   logic busy; // Request in progress.
   int err_total; // Mismatches.
   int n_tests; // Comparisons made.
   logic [31:0] mdl [16]; // Register contents as the bench expects them.
   cfg_msg_pkg::token_t expQ[$]; // Reply tokens the bench expects.

   cfg_msg_endpoint cfg_msg_endpoint_inst (.clk(clk), .rst_b(rst_b), .rxValid(rxValid),
      .rxTok(rxTok), .rxReady(rxReady), .txValid(txValid), .txTok(txTok),
      .txReady(txReady), .replyDest(replyDest), .busy(busy));
   cfg_requester_model cfg_requester_model_inst (.clk(clk), .slow(slow), .rxTok(rxTok),
      .rxValid(rxValid), .rxReady(rxReady), .txValid(txValid), .txTok(txTok),
      .txReady(txReady));

   // Clock of 5 ns period.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Sends one request, updates the model and checks the whole reply.
   task automatic req(input bit wr, input logic [23:0] id, input logic [15:0] rn,
         input logic [31:0] d, input bit badEnd);
      bit ok;
      int k;
      ok = (rn < `REG_COUNT) && !badEnd;
      cfg_requester_model_inst.sendTok({1'b1, wr ? `TOK_WRITE : `TOK_READ});
      for (k = 16; k >= 0; k -= 8) cfg_requester_model_inst.sendTok({1'b0, id[k+:8]});
      for (k = 8; k >= 0; k -= 8) cfg_requester_model_inst.sendTok({1'b0, rn[k+:8]});
      for (k = 24; k >= 0 && wr; k -= 8) cfg_requester_model_inst.sendTok({1'b0, d[k+:8]});
      cfg_requester_model_inst.sendTok({!badEnd, `TOK_END});
      cfg_requester_model_inst.relTok();
      `CHK(busy, 1'b1)
      if (wr && ok) begin
         mdl[rn[3:0]] = d;
      end
      if (!(wr && id[7:0] == `NO_REPLY_LOW)) begin
         expQ.push_back({1'b1, ok ? `TOK_ACK : `TOK_NACK});
         for (k = 24; k >= 0 && ok && !wr; k -= 8) expQ.push_back({1'b0, mdl[rn[3:0]][k+:8]});
         expQ.push_back({1'b1, `TOK_END});
      end
      k = 0;
      while (cfg_requester_model_inst.gotQ.size() < expQ.size() && k < 300) begin
         @(posedge clk);
         k++;
      end
      repeat (20) @(posedge clk);
      `CHK(busy, 1'b0)
      `CHK(cfg_requester_model_inst.gotQ.size(), expQ.size())
      foreach (expQ[j]) begin
         `CHK(cfg_requester_model_inst.gotQ[j], expQ[j])
      end
      if (expQ.size() > 0) begin
         `CHK(replyDest, id)
      end
      expQ.delete();
      cfg_requester_model_inst.gotQ.delete();
   endtask

   // Main sequence.
   initial begin
      int i;
      logic [23:0] id;
      logic [31:0] addrWord;
      err_total = 0;
      n_tests = 0;
      slow = 1'b0;
      rst_b = 1'b0;
      void'($urandom(32'h47B4));
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      // Fill every register, then read them back in reverse order.
      for (i = 0; i < 2 * `REG_COUNT; i++) begin
         slow = i[0];
         id = 24'($urandom) & 24'hFFFF7F;
         req(i < `REG_COUNT, id, 16'(i < `REG_COUNT ? i : 31 - i), $urandom, 1'b0);
      end
      $display("Test 1 done");
      // Unimplemented register numbers fail for write and read.
      req(1'b1, 24'h00A501, 16'h0010, $urandom, 1'b0);
      req(1'b0, 24'h00A502, 16'hFFFF, 32'h0, 1'b0);
      $display("Test 2 done");
      // Silent write, then read back proves it landed.
      // The register number is recovered from a status resource identifier.
      addrWord = (32'h0000_0005 << 8) | 32'h0000_000B;
      req(1'b1, 24'h1234FF, addrWord[23:8], $urandom, 1'b0);
      req(1'b0, 24'h123400, addrWord[23:8], 32'h0, 1'b0);
      $display("Test 3 done");
      // Wrong closing token fails and leaves the register alone.
      req(1'b1, 24'h00BE01, 16'h0007, $urandom, 1'b1);
      req(1'b0, 24'h00BE02, 16'h0007, 32'h0, 1'b0);
      $display("Test 4 done");
      // Stray data token in idle is dropped before a normal read.
      // An unknown header control token is dropped as well.
      cfg_requester_model_inst.sendTok({1'b1, 8'h55});
      cfg_requester_model_inst.sendTok({1'b0, 8'hC0});
      cfg_requester_model_inst.relTok();
      // Return channel-end taken from a destination word whose low byte is 02.
      addrWord = 32'h00C0_0302;
      req(1'b0, addrWord[31:8], 16'h000F, 32'h0, 1'b0);
      $display("Test 5 done");
      stop_test();
   end

   // Watchdog cuts a hang short.
   initial begin
      #200000;
      err_total++;
      $display("Error %0t: watchdog expired", $time);
      stop_test();
   end
endmodule
